// >>> hdl/sep_port.sv
/*
 * Serial command port of a sixteen-word, 16-bit nonvolatile memory,
 * with a two-entry command buffer in front of the programming engine.
 * Assumes select, shift_clock and serial_in are asynchronous pins and
 * that shift_clock is far slower than clk.
 */
//
// Notes on behaviour
// R1: nine-bit instruction: marker, opcode, address
// R2: instruction begins with a one bit
// R3: address opcodes decoded on upper two bits
// R4: 0011 unlock, 0000 lock, 0010/0001 every word
// R5: controller gives a clock before instruction
// R6: serial output driven only during read
// R7: read loads word, sends zero then data
// R8: output changes only on shift clock rise
// R9: programming only while unlocked, lock persists
// R10: read works regardless of lock state
// R11: erase starts at select fall, word ones
// R12: write takes sixteen bits, stores word; the code ANDs the sixteen bits into the current word
// R13: programming lasts while select stays low
// R14: controller keeps pulse 10 to 30 ms; bench host holds 400 clk (1.6 us)
// R15: controller raises select one clock afterwards
// R16: memory changes only during programming
// R17: erase every word sets all ones
// R18: write every word stores to all; the code ANDs the data into each word
// R19: clock may stop during programming pulse
// R20: select low 1 us between instructions
// R21: input sampled on clock rise, select high
// R22: locked programming leaves memory unchanged
`timescale 1ns/1ps

module sep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sep_fifo depth must be a power of two, at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr + PW'(push);
        next_rd_ptr = rd_ptr + PW'(pop);
        next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage holds no control state, so it needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : sep_fifo

module sep_port
    import sep_pkg::*;
#(
    parameter int WORDS = SEP_WORDS,
    parameter int WIDTH = SEP_WIDTH
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic select,
    input  wire logic shift_clock,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe_n,
    output logic      program_active
);
    if (WORDS != SEP_WORDS || WIDTH != SEP_WIDTH) begin : g_bad_geom
        $error("sep_port serves only sixteen 16-bit words");
    end

    if (HDR_LAST != 5'(2 * SEP_ABITS - 1) || DATA_LAST != 5'(WIDTH - 1)
        || READ_LAST != 5'(WIDTH)) begin : g_bad_count
        $error("sep_port bit counts disagree with the word geometry");
    end

    // pin synchronisers
    logic        sel_m, sel_s;
    logic        sk_m, sk_s, sk_d;
    logic        di_m, di_s;
    logic        sk_rise;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_m <= 1'b0;
            sel_s <= 1'b0;
            sk_m  <= 1'b0;
            sk_s  <= 1'b0;
            sk_d  <= 1'b0;
            di_m  <= 1'b0;
            di_s  <= 1'b0;
        end else begin
            sel_m <= select;
            sel_s <= sel_m;
            sk_m  <= shift_clock;
            sk_s  <= sk_m;
            sk_d  <= sk_s;
            di_m  <= serial_in;
            di_s  <= di_m;
        end
    end

    // data sampled alongside the clock, same synchroniser depth
    assign sk_rise = sk_s & ~sk_d & sel_s; // R21

    // command receiver
    sep_state_e  state, next_state;
    logic [4:0]  cnt, next_cnt;
    logic [6:0]  hdr, next_hdr;
    logic [15:0] shift, next_shift;
    logic        next_out, next_oe_n;
    logic        unlock, next_unlock;
    logic        pend, next_pend;
    sep_prog_s   cmd, next_cmd;
    logic [7:0]  full_hdr;

    logic        f_in_ready;
    logic        f_out_valid;
    logic        f_out_ready;
    sep_prog_s   f_out;

    logic [15:0] mem [SEP_WORDS];

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_hdr    = hdr;
        next_shift  = shift;
        next_out    = serial_out;
        next_oe_n   = serial_out_oe_n;
        next_unlock = unlock;
        next_pend   = pend;
        next_cmd    = cmd;
        full_hdr    = {hdr, di_s};
        // command leaves for the engine once select has fallen
        if (pend && !sel_s && f_in_ready) begin
            next_pend = 1'b0; // R11
        end
        // released output keeps its bit: only a counted rise moves it
        if (!sel_s) begin
            next_state = ST_IDLE;
            next_oe_n  = 1'b1; // R6 R8
        end else if (sk_rise) begin
            case (state)
                ST_IDLE: begin
                    // leading zeros are idle clocks, not instruction bits
                    if (di_s) begin
                        next_state = ST_HDR; // R2 R5
                        next_cnt   = '0;
                        next_pend  = 1'b0;
                    end
                end
                ST_HDR: begin
                    next_hdr = full_hdr[6:0];
                    next_cnt = cnt + 5'h01;
                    if (cnt == HDR_LAST) begin // R1
                        next_cnt      = '0;
                        next_state    = ST_DONE;
                        next_cmd.addr = full_hdr[3:0];
                        next_cmd.data = ERASED_WORD;
                        next_cmd.all  = 1'b0;
                        case (full_hdr[7:6]) // R3
                            OP_READ: begin
                                next_shift = mem[full_hdr[3:0]]; // R7 R10
                                next_out   = 1'b0;
                                next_oe_n  = 1'b0;
                                next_state = ST_READ;
                            end
                            OP_WRITE: begin
                                next_cmd.erase = 1'b0;
                                next_state     = ST_DATA;
                            end
                            OP_ERASE: begin
                                next_cmd.erase = 1'b1;
                                next_pend      = unlock; // R9 R22
                            end
                            default: begin
                                case (full_hdr[5:4]) // R4
                                    SUB_UNLOCK: next_unlock = 1'b1; // R9
                                    SUB_LOCK:   next_unlock = 1'b0;
                                    SUB_EALL: begin
                                        next_cmd.erase = 1'b1; // R17
                                        next_cmd.all   = 1'b1;
                                        next_pend      = unlock; // R22
                                    end
                                    default: begin
                                        next_cmd.erase = 1'b0; // R18
                                        next_cmd.all   = 1'b1;
                                        next_state     = ST_DATA;
                                    end
                                endcase
                            end
                        endcase
                    end
                end
                ST_DATA: begin
                    next_cmd.data = {cmd.data[14:0], di_s}; // R12
                    next_cnt      = cnt + 5'h01;
                    if (cnt == DATA_LAST) begin
                        next_pend  = unlock; // R9 R22
                        next_state = ST_DONE;
                    end
                end
                ST_READ: begin
                    // one bit per shift clock rise, msb first
                    next_out   = shift[15]; // R8
                    next_shift = {shift[14:0], 1'b0};
                    next_cnt   = cnt + 5'h01;
                    if (cnt == READ_LAST) begin
                        next_oe_n  = 1'b1; // R6
                        next_out   = 1'b0;
                        next_state = ST_DONE;
                    end
                end
                // rises after a whole instruction wait for select to fall
                ST_DONE: next_state = ST_DONE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state           <= ST_IDLE;
            cnt             <= '0;
            hdr             <= '0;
            shift           <= '0;
            serial_out      <= 1'b0;
            serial_out_oe_n <= 1'b1;
            unlock          <= UNLOCK_RST;
            pend            <= 1'b0;
            cmd             <= '0;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            hdr             <= next_hdr;
            shift           <= next_shift;
            serial_out      <= next_out;
            serial_out_oe_n <= next_oe_n;
            unlock          <= next_unlock;
            pend            <= next_pend;
            cmd             <= next_cmd;
        end
    end

    sep_fifo #(
        .WIDTH ($bits(sep_prog_s)),
        .DEPTH (SEP_FIFO_DEP)
    ) u_cmd_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (pend & ~sel_s),
        .in_ready  (f_in_ready),
        .in_data   (cmd),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out)
    );

    // programming engine: stalls the buffer while a pulse runs
    logic        next_active;
    logic [15:0] next_mem [SEP_WORDS];
    logic        take;

    // an entry whose select low was too short to start a pulse is
    // dropped once select rises, so a later select fall never replays it
    assign f_out_ready = ~program_active; // R16
    assign take        = f_out_valid & f_out_ready & ~sel_s; // R11

    always_comb begin
        next_active = program_active;
        next_mem    = mem;
        // the device does not time the pulse: select rising ends it
        if (program_active && sel_s) begin
            next_active = 1'b0; // R13
        end
        if (take) begin
            next_active = 1'b1; // R11 R13
            for (int i = 0; i < SEP_WORDS; i++) begin
                if (f_out.all || f_out.addr == 4'(i)) begin
                    // cells only lose charge on write, so unerased bits stay
                    next_mem[i] = f_out.erase ? ERASED_WORD
                                              : (mem[i] & f_out.data);
                end
            end
        end
    end

    // contents model the erased array state after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            program_active <= 1'b0;
            for (int i = 0; i < SEP_WORDS; i++) begin
                mem[i] <= ERASED_WORD;
            end
        end else begin
            program_active <= next_active;
            mem            <= next_mem;
        end
    end
endmodule : sep_port

// >>> hdl/sep_pkg.sv
/*
 * Shared constants and types for the serial word memory command port.
 * Assumes a single 250 MHz system clock; all pin timing is sampled.
 */
package sep_pkg;

    localparam int          SEP_WORDS    = 16;
    localparam int          SEP_WIDTH    = 16;
    localparam int          SEP_ABITS    = 4;
    localparam int          SEP_FIFO_DEP = 2;

    // bits after the lead marker: opcode then address
    localparam logic [4:0]  HDR_LAST     = 5'h07;
    localparam logic [4:0]  DATA_LAST    = 5'h0F;
    localparam logic [4:0]  READ_LAST    = 5'h10;

    // upper opcode bits
    localparam logic [1:0]  OP_SPECIAL   = 2'h0;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READ      = 2'h2;
    localparam logic [1:0]  OP_ERASE     = 2'h3;

    // lower opcode bits when the upper ones are zero
    localparam logic [1:0]  SUB_LOCK     = 2'h0;
    localparam logic [1:0]  SUB_WALL     = 2'h1;
    localparam logic [1:0]  SUB_EALL     = 2'h2;
    localparam logic [1:0]  SUB_UNLOCK   = 2'h3;

    localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
    localparam logic        UNLOCK_RST   = 1'b0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HDR  = 5'h02,
        ST_DATA = 5'h04,
        ST_READ = 5'h08,
        ST_DONE = 5'h10
    } sep_state_e;

    typedef struct packed {
        logic        erase;
        logic        all;
        logic [3:0]  addr;
        logic [15:0] data;
    } sep_prog_s;

endpackage : sep_pkg

// >>> bench/sep_port_props.sv
/* Assertion checker for the serial memory port, bound to sep_port.
   Assumes raw pins: a shift clock rise shows at the outputs 3 clk on. */
`timescale 1ns/1ps
module sep_port_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic select,
    input wire logic shift_clock,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic program_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_oe_idle; !select [*5] |-> serial_out_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("pin driven");
    property p_do_edge;
        $changed(serial_out) |-> $past(shift_clock, 3) || $past(shift_clock, 4);
    endproperty
    a_do_edge: assert property (p_do_edge) else $error("late data");
    property p_dummy;
        $fell(serial_out_oe_n) |-> !serial_out && $past(select, 4);
    endproperty
    a_dummy: assert property (p_dummy) else $error("no zero");
    property p_oe_hold;
        $fell(serial_out_oe_n) |=> !serial_out_oe_n [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("short drive");
    property p_prog_start;
        $rose(program_active) |-> !select && !$past(select, 2);
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("early");
    property p_prog_end; $rose(select) |-> ##[1:5] !program_active; endproperty
    a_prog_end: assert property (p_prog_end) else $error("no end");
    property p_prog_hold; program_active && !select |=> program_active; endproperty
    a_prog_hold: assert property (p_prog_hold) else $error("cut");
    property p_quiet; program_active |-> serial_out_oe_n; endproperty
    a_quiet: assert property (p_quiet) else $error("drive in pulse");

    c_read: cover property ($fell(serial_out_oe_n));
    c_prog: cover property ($rose(program_active));
    c_end: cover property ($fell(program_active));
endmodule : sep_port_props

bind sep_port sep_port_props u_props (.clk(clk), .arst_n(arst_n),
    .select(select), .shift_clock(shift_clock), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .program_active(program_active));

// >>> bench/sep_host.sv
/* Controller model: drives select, shift clock and serial input.
   Assumes the bench calls run from a process clocked by clk. */
`timescale 1ns/1ps
module sep_host (
    input  wire logic clk,
    output logic      select,
    output logic      shift_clock,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n,
    input  wire logic program_active
);
    localparam int HALF  = 8;   // keeps serial_in steady round each rise
    localparam int PULSE = 400; // short stand-in, device does not time it
    logic wire_do;
    logic last_do;
    int   pulse;

    // released pin floats: show the inverse of its last level
    assign wire_do = serial_out_oe_n ? ~last_do : serial_out;
    always @(posedge clk) begin
        if (!serial_out_oe_n)
            last_do <= serial_out;
    end
    initial begin
        select      = 1'b0;
        shift_clock = 1'b0;
        serial_in   = 1'b0;
        last_do     = 1'b0;
        pulse       = PULSE;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic tick(input logic b, output logic o, output logic oe);
        serial_in <= b;
        wt(HALF);
        shift_clock <= 1'b1;
        wt(HALF);
        @(negedge clk);
        o  = wire_do;
        oe = serial_out_oe_n;
        @(posedge clk);
        shift_clock <= 1'b0;
    endtask : tick

    task automatic run(input logic [3:0] op, input logic [3:0] adr,
                       input logic [15:0] dat, input int pre, input int cut,
                       output logic [17:0] rd, output logic pls);
        logic [24:0] bits;
        logic        o;
        logic        oe;
        int          n;
        bits = {1'h1, op, adr, dat};
        n    = (op[3:2] == 2'h1 || op == 4'h1) ? 25 : 9;
        if (cut > 0)
            n = cut;
        rd  = 18'h0;
        pls = 1'h0;
        @(posedge clk);
        select <= 1'h1;
        repeat (pre) tick(1'h0, o, oe);
        for (int i = 24; i > 24 - n; i--)
            tick(bits[i], o, oe);
        if (op[3:2] == 2'h2 && cut == 0) begin
            rd[16] = o;
            for (int i = 15; i >= 0; i--) begin
                tick(1'h0, o, oe);
                rd[i] = o;
            end
            tick(1'h0, o, oe);
            rd[17] = oe;
        end
        select <= 1'h0;
        repeat (pulse) begin
            @(negedge clk);
            if (program_active === 1'h1)
                pls = 1'h1;
        end
        @(posedge clk);
        select <= 1'h1;
        wt(2 * HALF + 1); // a full shift clock period
        select <= 1'h0;
        wt(300);
    endtask : run
endmodule : sep_host

// >>> bench/sep_port_tb_top.sv
/* Bench top: instruction table through the controller model, then
   leading zeros, a cut instruction and a reset in mid-run. */
`timescale 1ns/1ps
module sep_port_tb_top;
    typedef struct packed {
        logic [3:0]  op;
        logic [3:0]  adr;
        logic [15:0] dat;
        logic [15:0] exp;
        logic        pls;
    } sep_row_s;
    logic        clk, arst_n, select, shift_clock, serial_in;
    logic        serial_out, serial_out_oe_n, program_active, pls;
    logic [17:0] rd;
    int          failures, compares;
    sep_row_s    rows [14];

    sep_port dut (.clk(clk), .arst_n(arst_n), .select(select),
        .shift_clock(shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .program_active(program_active));
    sep_host host (.clk(clk), .select(select), .shift_clock(shift_clock),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .program_active(program_active));

    initial clk = 1'h0;
    always #2 clk = ~clk;

    task automatic check_word(input string name, input logic [17:0] exp,
                              input logic [17:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic do_row(input sep_row_s r, input int pre, input int cut);
        host.run(r.op, r.adr, r.dat, pre, cut, rd, pls);
        if (r.op[3:2] == 2'h2)
            check_word("read", {2'h2, r.exp}, rd);
        check_bit("pulse", r.pls, pls);
    endtask : do_row

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("Error timeout expected done seen running");
        test_done();
    end

    initial begin
        arst_n   = 1'h0;
        failures = 0;
        compares = 0;
        rows = '{
            '{4'h3, 4'h9, 16'h0000, 16'h0000, 1'h0},
            '{4'h2, 4'h0, 16'h0000, 16'h0000, 1'h1},
            '{4'h1, 4'h7, 16'h5AC3, 16'h0000, 1'h1},
            '{4'h8, 4'h0, 16'h0000, 16'h5AC3, 1'h0},
            '{4'hB, 4'hF, 16'h0000, 16'h5AC3, 1'h0},
            '{4'hE, 4'h3, 16'h0000, 16'h0000, 1'h1},
            '{4'h9, 4'h3, 16'h0000, 16'hFFFF, 1'h0},
            '{4'h6, 4'h3, 16'hA55A, 16'h0000, 1'h1},
            '{4'hA, 4'h3, 16'h0000, 16'hA55A, 1'h0},
            '{4'h0, 4'h5, 16'h0000, 16'h0000, 1'h0},
            '{4'hC, 4'h3, 16'h0000, 16'h0000, 1'h0},
            '{4'h2, 4'h0, 16'h0000, 16'h0000, 1'h0},
            '{4'h8, 4'h3, 16'h0000, 16'hA55A, 1'h0},
            '{4'h8, 4'h2, 16'h0000, 16'h5AC3, 1'h0}
        };
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        @(negedge clk);
        check_bit("oe_n", 1'h1, serial_out_oe_n);
        check_bit("active", 1'h0, program_active);
        foreach (rows[i])
            do_row(rows[i], 1, 0);
        // idle zeros ahead of the marker are skipped
        do_row(sep_row_s'{4'h8, 4'h3, 16'h0, 16'hA55A, 1'h0}, 4, 0);
        do_row(rows[0], 1, 0);
        // erase cut after six bits is dropped
        do_row(sep_row_s'{4'hE, 4'h3, 16'h0, 16'h0, 1'h0}, 1, 6);
        do_row(rows[12], 1, 0);
        // select low for one clock: the erase is dropped, never replayed
        host.pulse = 1;
        do_row(sep_row_s'{4'hE, 4'h3, 16'h0, 16'h0, 1'h0}, 1, 0);
        host.pulse = 400;
        do_row(rows[12], 1, 0);
        @(posedge clk);
        arst_n <= 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        @(negedge clk);
        check_bit("oe_n", 1'h1, serial_out_oe_n);
        check_bit("active", 1'h0, program_active);
        // reset relocks, so this write must not touch the word
        do_row(sep_row_s'{4'h5, 4'h3, 16'h0, 16'h0, 1'h0}, 1, 0);
        do_row(sep_row_s'{4'h8, 4'h3, 16'h0, 16'hFFFF, 1'h0}, 1, 0);
        test_done();
    end
endmodule : sep_port_tb_top
